// file: ccu_defs.svh
// Constants for the dual capture/compare unit
`ifndef CCU_DEFS_SVH
`define CCU_DEFS_SVH
// ==========================================
// Register offsets (byte addresses)
`define CCU_ADDR_W        8
`define CCU_OFF_CTRL1     8'h00
`define CCU_OFF_DATAL1    8'h04
`define CCU_OFF_DATAH1    8'h08
`define CCU_OFF_CTRL2     8'h0c
`define CCU_OFF_DATAL2    8'h10
`define CCU_OFF_DATAH2    8'h14
`define CCU_OFF_FLAGS     8'h18
`define CCU_OFF_STATUS    8'h1c
// ==========================================
// Field positions and reset values
`define CCU_MODE_LSB      0
`define CCU_MODE_MSB      3
`define CCU_FLAG1_BIT     0
`define CCU_FLAG2_BIT     1
`define CCU_CTRL_RST      8'h00
`define CCU_DATA_RST      8'h00
// ==========================================
// Capture prescale counts
`define CCU_PS4_LAST      4'h3
`define CCU_PS16_LAST     4'hf
`endif

// file: ccu_far_model.sv
// Pin source and general timer facing the capture/compare unit
`timescale 1ns/10ps
module ccu_far_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Trigger and pin requests
	input  wire logic        timer_reset_i,
	input  wire logic [2:0]  pin_set_i,
	// Timer and pin levels
	output logic      [15:0] timer_o = 16'h0000,
	output logic      [2:0]  pin_o   = 3'h0
);
	// Timer runs synchronously on the unit clock
	always @(posedge clk_i) begin
		if (rst_i || timer_reset_i) begin
			timer_o <= 16'h0000;
		end else begin
			timer_o <= timer_o + 16'h0001;
		end
	end
	// Pin levels follow the request one cycle later
	always @(posedge clk_i) begin
		pin_o <= rst_i ? 3'h0 : pin_set_i;
	end
endmodule

// file: ccu_pkg.sv
// Types for the dual capture/compare unit
package ccu_pkg;
	// Mode field encodings
	typedef enum logic [3:0] {
		CCU_OFF      = 4'h0,
		CCU_CMP_TOG  = 4'h2,
		CCU_CAP_FALL = 4'h4,
		CCU_CAP_RISE = 4'h5,
		CCU_CAP_4TH  = 4'h6,
		CCU_CAP_16TH = 4'h7,
		CCU_CMP_HIGH = 4'h8,
		CCU_CMP_LOW  = 4'h9,
		CCU_CMP_SW   = 4'ha,
		CCU_CMP_TRIG = 4'hb
	} ccu_mode_t;
endpackage

// file: ccu_top.sv
// Two capture/compare units sharing the general timer
// Function
// - Capture and compare use the 16-bit general timer; PWM units stay independent.
// - Both units run together sharing one general timer.
// - Second unit pin routes to port C when config is 1, else port B.
// - Capture copies full 16-bit timer into data pair on event.
// - Event selects falling, rising, every 4th or every 16th rising edge.
// - Each capture sets flag; only software clears it.
// - A newer capture overwrites an unread value.
// - Edge detector watches the pin itself, even while driven as output.
// - Prescaler clears when off, capture left, or reset.
// - Switching between prescale settings keeps the prescaler count.
// - Compare matches data register with timer; action and flag same cycle.
// - Match drives high, low, toggles, or leaves port latch on pin.
// - Clearing second control forces its compare latch low.
// - Compare trigger of either unit resets the shared timer.
// - Only second unit trigger starts an analog conversion.
// - PWM units share one period timer.
// - Capture codes 0100, 0101, 0110, 0111.
// - Compare codes 0010, 1000, 1001, 1010, 1011 all set the flag.
// - Mode 0000 disables the unit and clears its prescaler and compare latch; data pair and flag keep their values.
// - Trigger resets the time base timer pair.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "ccu_defs.svh"
module ccu_top #(
	parameter int TW = 16
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Register port
	input  wire logic [`CCU_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rdata_o,
	// Timer link and configuration
	input  wire logic [TW-1:0]          general_timer_count_i,
	input  wire logic                   second_pin_route_cfg_i,
	output logic                        timer_reset_o,
	output logic                        start_conversion_o,
	output logic      [1:0]             unit_event_flag_o,
	// Pins and port latches
	input  wire logic                   first_pin_i,
	input  wire logic                   port_c_pin_i,
	input  wire logic                   port_b_pin_i,
	input  wire logic                   first_port_latch_i,
	input  wire logic                   second_port_latch_i,
	output logic                        first_pin_o,
	output logic                        port_c_pin_o,
	output logic                        port_b_pin_o,
	output logic      [1:0]             unit_drives_pin_o
);
	import ccu_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m[3:2] == 2'b01);
	endfunction
	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == CCU_CMP_TOG) || (m[3:2] == 2'b10);
	endfunction

	// ==========================================
	// State
	logic [3:0]    mode_reg [2];
	logic [3:0]    mode_next [2];
	logic [TW-1:0] data_reg [2];
	logic [TW-1:0] data_next [2];
	logic [3:0]    ps_reg [2];
	logic [3:0]    ps_next [2];
	logic [1:0]    flag_reg, flag_next;
	logic [1:0]    latch_reg, latch_next;
	logic [2:0]    sync_reg [2];
	logic [2:0]    sync_next [2];
	logic [1:0]    lvl_reg, lvl_next;
	logic [7:0]    rdata_reg, rdata_next;
	logic [1:0]    rise, fall, cap_ev, match, trig;
	logic [1:0]    pin_raw;
	logic [TW-1:0] tmr;

	assign tmr = general_timer_count_i;
	// Pin observed directly, second unit routed by config
	assign pin_raw[0] = first_pin_i;
	assign pin_raw[1] = second_pin_route_cfg_i ? port_c_pin_i : port_b_pin_i;

	// Edge detection and match per unit
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			sync_next[u] = {sync_reg[u][1:0], pin_raw[u]};
			lvl_next[u]  = (sync_reg[u][1] == sync_reg[u][2]) ? sync_reg[u][2] : lvl_reg[u];
			rise[u]      = lvl_next[u] & ~lvl_reg[u];
			fall[u]      = ~lvl_next[u] & lvl_reg[u];
			match[u]     = is_compare(mode_reg[u]) && (data_reg[u] == tmr);
			trig[u]      = match[u] && (mode_reg[u] == CCU_CMP_TRIG);
		end
	end

	// Capture prescaler and event selection
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			ps_next[u] = ps_reg[u];
			cap_ev[u]  = 1'b0;
			case (mode_reg[u])
				CCU_CAP_FALL: cap_ev[u] = fall[u];
				CCU_CAP_RISE: cap_ev[u] = rise[u];
				CCU_CAP_4TH: begin
					if (rise[u]) begin
						cap_ev[u]  = (ps_reg[u][1:0] == 2'(`CCU_PS4_LAST));
						ps_next[u] = ps_reg[u] + 4'h1;
					end
				end
				CCU_CAP_16TH: begin
					if (rise[u]) begin
						cap_ev[u]  = (ps_reg[u] == `CCU_PS16_LAST);
						ps_next[u] = ps_reg[u] + 4'h1;
					end
				end
				default: ps_next[u] = 4'h0;
			endcase
		end
	end

	// Register writes, capture, flags, compare latch
	always_comb begin
		flag_next  = flag_reg;
		latch_next = latch_reg;
		rdata_next = 8'h00;
		for (int u = 0; u < 2; u++) begin
			mode_next[u] = mode_reg[u];
			data_next[u] = data_reg[u];
		end
		// Software side first, hardware events override below
		if (wr_i) begin
			if (addr_i == `CCU_OFF_CTRL1) begin
				mode_next[0] = wdata_i[`CCU_MODE_MSB:`CCU_MODE_LSB];
			end else if (addr_i == `CCU_OFF_CTRL2) begin
				mode_next[1] = wdata_i[`CCU_MODE_MSB:`CCU_MODE_LSB];
			end else if (addr_i == `CCU_OFF_DATAL1) begin
				data_next[0][7:0] = wdata_i;
			end else if (addr_i == `CCU_OFF_DATAH1) begin
				data_next[0][TW-1:8] = wdata_i;
			end else if (addr_i == `CCU_OFF_DATAL2) begin
				data_next[1][7:0] = wdata_i;
			end else if (addr_i == `CCU_OFF_DATAH2) begin
				data_next[1][TW-1:8] = wdata_i;
			end else if (addr_i == `CCU_OFF_FLAGS) begin
				flag_next = flag_reg & ~wdata_i[1:0];
			end
		end
		for (int u = 0; u < 2; u++) begin
			if (match[u]) begin
				flag_next[u] = 1'b1;
				case (mode_reg[u])
					CCU_CMP_TOG:  latch_next[u] = ~latch_reg[u];
					CCU_CMP_HIGH: latch_next[u] = 1'b1;
					CCU_CMP_LOW:  latch_next[u] = 1'b0;
					default:      latch_next[u] = latch_reg[u];
				endcase
			end
			// Initial pin level when drive high or drive low is written, low when off is written; wins over a match
			if (wr_i && mode_next[u] != mode_reg[u]) begin
				if (mode_next[u] == CCU_CMP_HIGH) begin
					latch_next[u] = 1'b0;
				end else if (mode_next[u] == CCU_CMP_LOW) begin
					latch_next[u] = 1'b1;
				end else if (mode_next[u] == CCU_OFF) begin
					latch_next[u] = 1'b0;
				end
			end
			if (cap_ev[u] && is_capture(mode_reg[u])) begin
				data_next[u] = tmr;
				flag_next[u] = 1'b1;
			end
		end
		// Read decode
		if (rd_i) begin
			if (addr_i == `CCU_OFF_CTRL1) begin
				rdata_next = {4'h0, mode_reg[0]};
			end else if (addr_i == `CCU_OFF_CTRL2) begin
				rdata_next = {4'h0, mode_reg[1]};
			end else if (addr_i == `CCU_OFF_DATAL1) begin
				rdata_next = data_reg[0][7:0];
			end else if (addr_i == `CCU_OFF_DATAH1) begin
				rdata_next = data_reg[0][TW-1:8];
			end else if (addr_i == `CCU_OFF_DATAL2) begin
				rdata_next = data_reg[1][7:0];
			end else if (addr_i == `CCU_OFF_DATAH2) begin
				rdata_next = data_reg[1][TW-1:8];
			end else if (addr_i == `CCU_OFF_FLAGS) begin
				rdata_next = {6'h00, flag_reg};
			end else if (addr_i == `CCU_OFF_STATUS) begin
				rdata_next = {4'h0, lvl_reg, latch_reg};
			end
		end
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int u = 0; u < 2; u++) begin
				mode_reg[u] <= 4'(`CCU_CTRL_RST);
				data_reg[u] <= TW'(`CCU_DATA_RST);
				ps_reg[u]   <= 4'h0;
				sync_reg[u] <= 3'h0;
			end
			flag_reg  <= 2'h0;
			latch_reg <= 2'h0;
			lvl_reg   <= 2'h0;
			rdata_reg <= 8'h00;
		end else begin
			for (int u = 0; u < 2; u++) begin
				mode_reg[u] <= mode_next[u];
				data_reg[u] <= data_next[u];
				ps_reg[u]   <= ps_next[u];
				sync_reg[u] <= sync_next[u];
			end
			flag_reg  <= flag_next;
			latch_reg <= latch_next;
			lvl_reg   <= lvl_next;
			rdata_reg <= rdata_next;
		end
	end

	// Pin outputs: latch in drive modes, port latch otherwise
	logic [1:0] drive;
	logic [1:0] pin_val;
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			drive[u] = is_compare(mode_reg[u]) && (mode_reg[u] != CCU_CMP_SW) &&
				(mode_reg[u] != CCU_CMP_TRIG);
		end
		pin_val[0] = drive[0] ? latch_reg[0] : first_port_latch_i;
		pin_val[1] = drive[1] ? latch_reg[1] : second_port_latch_i;
	end
	assign first_pin_o        = pin_val[0];
	assign port_c_pin_o       = second_pin_route_cfg_i ? pin_val[1] : 1'b0;
	assign port_b_pin_o       = second_pin_route_cfg_i ? 1'b0 : pin_val[1];
	assign unit_drives_pin_o  = drive;
	assign timer_reset_o      = |trig;
	assign start_conversion_o = trig[1];
	assign unit_event_flag_o  = flag_reg;
	assign rdata_o            = rdata_reg;

	// ==========================================
	// Assertions
	capture_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap_ev[0] && is_capture(mode_reg[0]) |=> data_reg[0] == $past(tmr))
		else $error("capture did not copy timer");
	capture_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap_ev[1] && is_capture(mode_reg[1]) |=> flag_reg[1])
		else $error("capture flag not set");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_reg[0] && !(wr_i && addr_i == `CCU_OFF_FLAGS) |=> flag_reg[0])
		else $error("flag cleared by hardware");
	match_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match[0] |=> flag_reg[0])
		else $error("compare flag missing");
	match_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match[0] && mode_reg[0] == CCU_CMP_HIGH && !wr_i |=> latch_reg[0])
		else $error("drive high failed");
	prescale_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!is_capture(mode_reg[1]) |=> ps_reg[1] == 4'h0)
		else $error("prescaler not cleared");
	trig_conv_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_conversion_o |-> mode_reg[1] == CCU_CMP_TRIG && timer_reset_o)
		else $error("conversion without second trigger");
	second_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `CCU_OFF_CTRL2 && wdata_i == 8'h00 |=> !latch_reg[1])
		else $error("second latch not cleared");
	route_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!second_pin_route_cfg_i |-> !port_c_pin_o)
		else $error("port c driven while routed to b");

	// ==========================================
	// Named steps of a capture and of a compare match
	sequence cap0_seq;
		cap_ev[0] && is_capture(mode_reg[0]);
	endsequence
	sequence cap1_seq;
		cap_ev[1] && is_capture(mode_reg[1]);
	endsequence
	sequence low0_seq;
		match[0] && !wr_i && mode_reg[0] == CCU_CMP_LOW;
	endsequence
	sequence tog0_seq;
		match[0] && !wr_i && mode_reg[0] == CCU_CMP_TOG;
	endsequence

	// Capture path of both units
	capture_copy1_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap1_seq |=> data_reg[1] == $past(tmr))
		else $error("second capture did not copy timer");
	capture_flag0_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap0_seq |=> flag_reg[0])
		else $error("first capture flag not set");
	flag_hold1_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_reg[1] && !(wr_i && addr_i == `CCU_OFF_FLAGS) |=> flag_reg[1])
		else $error("second flag cleared by hardware");
	fourth_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_reg[0] == CCU_CAP_4TH && rise[0] && ps_reg[0][1:0] != 2'(`CCU_PS4_LAST)
		|-> !cap_ev[0])
		else $error("early fourth edge capture");
	sixteenth_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_reg[1] == CCU_CAP_16TH && rise[1] && ps_reg[1] != `CCU_PS16_LAST |-> !cap_ev[1])
		else $error("early sixteenth edge capture");
	prescale_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_reg[0] == CCU_OFF |=> ps_reg[0] == 4'h0)
		else $error("prescaler kept while off");
	prescale_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_capture(mode_reg[0]) && !rise[0] |=> ps_reg[0] == $past(ps_reg[0]))
		else $error("prescaler changed without edge");
	sync_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rise[0] |-> sync_reg[0][2] && sync_reg[0][1])
		else $error("edge seen before synchroniser agreed");

	// Compare path, pin actions and triggers
	match_flag1_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match[1] |=> flag_reg[1])
		else $error("second compare flag missing");
	match_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		low0_seq |=> !latch_reg[0])
		else $error("drive low failed");
	match_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tog0_seq |=> latch_reg[0] != $past(latch_reg[0]))
		else $error("toggle failed");
	latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_reg[1] == CCU_CMP_SW && !wr_i |=> latch_reg[1] == $past(latch_reg[1]))
		else $error("latch moved in signal only mode");
	pin_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		drive[1] |-> (second_pin_route_cfg_i ? port_c_pin_o : port_b_pin_o) == latch_reg[1])
		else $error("second pin not from compare latch");
	timer_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match[0] && mode_reg[0] == CCU_CMP_TRIG |-> timer_reset_o)
		else $error("first trigger did not reset timer");
	conv_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match[0] && mode_reg[0] == CCU_CMP_TRIG && !trig[1] |-> !start_conversion_o)
		else $error("first unit started conversion");
	route_c_a: assert property (@(posedge clk_i) disable iff (rst_i)
		second_pin_route_cfg_i |-> !port_b_pin_o)
		else $error("port b driven while routed to c");
	rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
endmodule

// file: ccu_top_tb.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`include "ccu_defs.svh"
`define CHK(n,e,s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module ccu_top_tb;
	import ccu_pkg::*;
	logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, rd_q = 0, cfg = 1, hold = 1;
	logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o, e_rd;
	logic [15:0] tval = 0, tmod, gtc;
	logic [2:0]  pin = 0, lvl;
	logic [1:0]  lat = 0, flg, drv;
	logic        trst, conv, p0, pc, pb;
	logic [7:0]  expq[$];
	int          num_errors = 0, n_compared = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	assign gtc = hold ? tval : tmod;
	ccu_top i_ccu_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .general_timer_count_i(gtc),
		.second_pin_route_cfg_i(cfg), .timer_reset_o(trst), .start_conversion_o(conv),
		.unit_event_flag_o(flg), .first_pin_i(lvl[0]), .port_c_pin_i(lvl[1]),
		.port_b_pin_i(lvl[2]), .first_port_latch_i(lat[0]), .second_port_latch_i(lat[1]),
		.first_pin_o(p0), .port_c_pin_o(pc), .port_b_pin_o(pb), .unit_drives_pin_o(drv));
	ccu_far_model i_ccu_far_model (.clk_i(clk_i), .rst_i(rst_i), .timer_reset_i(trst),
		.pin_set_i(pin), .timer_o(tmod), .pin_o(lvl));
	// Read data checker and hang guard
	always @(posedge clk_i) begin
		rd_q <= rd_i;
		cyc++;
		if (rd_q) begin
			e_rd = expq.pop_front();
			`CHK("rdata", e_rd, rdata_o)
		end
		if (cyc == 5000) begin
			num_errors++;
			summarize();
		end
	end
	// One bus cycle
	task automatic go(input logic w, r, input logic [7:0] a, d);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, e);
		expq.push_back(e);
		go(0, 1, a, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) go(0, 0, 8'h00, 8'h00);
	endtask
	// Edge train on one pin, prescale and overwrite checked
	task automatic cap(input int u, p, div, input logic fall, input ccu_mode_t m);
		logic [7:0]  b;
		logic [15:0] v;
		b = u ? `CCU_OFF_CTRL2 : `CCU_OFF_CTRL1;
		pin[p] <= fall;
		idle(8);
		go(1, 0, b, 8'h00);
		go(1, 0, b, {4'h0, m});
		go(1, 0, `CCU_OFF_FLAGS, 8'h03);
		for (int k = 1; k <= 2 * div; k++) begin
			v = 16'($urandom);
			tval <= v;
			pin[p] <= !fall;
			idle(8);
			pin[p] <= fall;
			idle(8);
			if (k >= div - 1) `CHK("flag", k >= div, flg[u])
		end
		rd(b + 8'h04, v[7:0]);
		rd(b + 8'h08, v[15:8]);
		idle(2);
		$display("capture test mode %h unit %0d done", m, u);
	endtask
	// One compare match of a single cycle
	task automatic cmp(input int u, input ccu_mode_t m, input logic bf, af);
		logic [7:0]  b;
		logic [15:0] v;
		b = u ? `CCU_OFF_CTRL2 : `CCU_OFF_CTRL1;
		v = 16'($urandom);
		tval <= v + 16'h0001;
		go(1, 0, b, 8'h00);
		go(1, 0, b + 8'h04, v[7:0]);
		go(1, 0, b + 8'h08, v[15:8]);
		go(1, 0, b, {4'h0, m});
		go(1, 0, `CCU_OFF_FLAGS, 8'h03);
		idle(2);
		`CHK("pin before", bf, u ? pc : p0)
		tval <= v;
		#1;
		`CHK("timer reset", m == CCU_CMP_TRIG, trst)
		`CHK("conversion", m == CCU_CMP_TRIG && u == 1, conv)
		@(posedge clk_i);
		tval <= v + 16'h0001;
		#1;
		`CHK("flag", 1'b1, flg[u])
		`CHK("pin after", af, u ? pc : p0)
		`CHK("drives", m inside {CCU_CMP_TOG, CCU_CMP_HIGH, CCU_CMP_LOW}, drv[u])
		$display("compare test mode %h unit %0d done", m, u);
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		logic [7:0]  w;
		logic [15:0] tv;
		void'($urandom(32'h1ce5cbaf));
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 8'h00);
		w = 8'($urandom);
		go(1, 0, 8'h20, 8'hff);
		go(1, 0, `CCU_OFF_DATAH2, w);
		rd(8'h20, 8'h00);
		rd(`CCU_OFF_DATAH2, w);
		$display("register test done");
		cap(0, 0, 1, 1'b1, CCU_CAP_FALL);
		cap(0, 0, 1, 1'b0, CCU_CAP_RISE);
		cap(0, 0, 4, 1'b0, CCU_CAP_4TH);
		cap(1, 1, 16, 1'b0, CCU_CAP_16TH);
		cfg <= 0;
		cap(1, 2, 1, 1'b0, CCU_CAP_RISE);
		pin <= 3'h0;
		lat <= 2'b11;
		cfg <= 1;
		cmp(0, CCU_CMP_TOG, 1'b0, 1'b1);
		cmp(0, CCU_CMP_HIGH, 1'b0, 1'b1);
		cmp(0, CCU_CMP_LOW, 1'b1, 1'b0);
		cmp(0, CCU_CMP_SW, 1'b1, 1'b1);
		cmp(0, CCU_CMP_TRIG, 1'b1, 1'b1);
		cmp(1, CCU_CMP_TRIG, 1'b1, 1'b1);
		cmp(1, CCU_CMP_HIGH, 1'b0, 1'b1);
		`CHK("unrouted pin", 1'b0, pb)
		rd(`CCU_OFF_STATUS, 8'h02);
		go(1, 0, `CCU_OFF_CTRL2, 8'h00);
		rd(`CCU_OFF_STATUS, 8'h00);
		// Trigger on the running timer wraps it below the compare value
		go(1, 0, `CCU_OFF_CTRL1, 8'h00);
		hold <= 0;
		tv = tmod + 16'h0014;
		go(1, 0, `CCU_OFF_DATAL1, tv[7:0]);
		go(1, 0, `CCU_OFF_DATAH1, tv[15:8]);
		go(1, 0, `CCU_OFF_FLAGS, 8'h03);
		go(1, 0, `CCU_OFF_CTRL1, {4'h0, CCU_CMP_TRIG});
		idle(40);
		`CHK("timer wrap", 1'b1, tmod < tv)
		`CHK("trigger flag", 1'b1, flg[0])
		$display("timer trigger test done");
		idle(3);
		summarize();
	end
endmodule
